// ### dv/jtag_programmer.sv
// Behavioural test port programmer that drives clock, mode and both data pins.
`timescale 1ns/1ps
module jtag_programmer (
  // Test port pins.
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_alt_tdi,
  input wire logic i_tdo
);
  int half_ns = 32;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_alt_tdi = 1'b1;
  end
  // Mode and data change while the clock is low, so the rising edge sees them settled.
  // The unused data pin carries the inverse so that a wrong input choice shows up.
  task automatic pulse(input logic tms, input logic d, input logic alt, output logic tdo);
    o_tms = tms;
    o_tdi = alt ? ~d : d;
    o_alt_tdi = alt ? d : ~d;
    #(half_ns);
    tdo = i_tdo;
    o_tck = 1'b1;
    #(half_ns);
    o_tck = 1'b0;
  endtask
  // Clock stands still between frames and the pulled-up data pins return high.
  task automatic release_pins();
    o_tdi = 1'b1;
    o_alt_tdi = 1'b1;
  endtask
  task automatic reset_walk();
    logic t;
    repeat (5) pulse(1'b1, 1'b1, 1'b0, t);
    pulse(1'b0, 1'b1, 1'b0, t);
    release_pins();
  endtask
  // A blind pass: capture, exit and update with no shift; standard data pin driven high, alternate low.
  task automatic ir_walk();
    logic t;
    pulse(1'b1, 1'b1, 1'b0, t);
    pulse(1'b1, 1'b1, 1'b0, t);
    pulse(1'b0, 1'b1, 1'b0, t);
    pulse(1'b1, 1'b1, 1'b0, t);
    pulse(1'b1, 1'b1, 1'b0, t);
    pulse(1'b0, 1'b1, 1'b0, t);
  endtask
  // Only clock and mode steer the walk; the code rides on the chosen data pin.
  task automatic ir_load(input logic [7:0] code, input logic alt);
    logic t;
    pulse(1'b1, 1'b1, alt, t);
    pulse(1'b1, 1'b1, alt, t);
    pulse(1'b0, 1'b1, alt, t);
    pulse(1'b0, 1'b1, alt, t);
    for (int i = 0; i < 8; i++) begin
      pulse(i == 7, code[i], alt, t);
    end
    pulse(1'b1, 1'b1, alt, t);
    pulse(1'b0, 1'b1, alt, t);
    release_pins();
  endtask
  // The device is last in the chain, so its output returns straight here.
  task automatic dr_read(input logic alt, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    pulse(1'b1, 1'b1, alt, t);
    pulse(1'b0, 1'b1, alt, t);
    pulse(1'b0, 1'b1, alt, t);
    for (int i = 0; i < 32; i++) begin
      pulse(i == 31, din[i], alt, dout[i]);
    end
    pulse(1'b1, 1'b1, alt, t);
    pulse(1'b0, 1'b1, alt, t);
    release_pins();
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the alternate data input select block.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] ID = 32'h0badf00d; // Arbitrary identification value.
  logic i_mclk, i_rst_b, tck, tms, tdi, alt_tdi, strap, strap_oe, programming_only_supply, tdo, tdo_oe, alt_sel;
  logic [3:0] func_in, func_in_q;
  logic [11:0] func_out, func_out_q, func_oe;
  logic [1:0] hv, hv_gd, hv_q;
  logic [31:0] sig, cfg, seed, dout;
  logic fuse;
  int fail_count = 0;
  int n_checks = 0;
  int ld_count = 0;
  logic ovr = 1'b0;
  tdi_select #(.ID_VALUE(ID)) u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_alternate_serial_data_in(alt_tdi),
    .i_data_input_select_strap(strap), .i_data_input_select_strap_oe(strap_oe), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_programming_only_supply(programming_only_supply), .i_func_in(func_in),
    .i_func_out(func_out),
    .i_high_voltage_gate_output(hv), .i_hv_is_gate_driver(hv_gd), .o_func_out(func_out_q),
    .o_func_out_oe(func_oe), .o_high_voltage_gate_output(hv_q), .o_func_in(func_in_q),
    .o_user_signature_word(sig), .o_config(cfg), .o_readback_security_fuse(fuse),
    .o_alt_selected(alt_sel));
  jtag_programmer u_prog (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_alt_tdi(alt_tdi),
    .i_tdo(tdo));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // An undriven strap reads high in the reference model too.
  function automatic logic exp_alt();
    return !(strap_oe ? strap : 1'b1) || ovr;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Loads each code, updates the count model and compares the selected input.
  task automatic run_codes(input logic [7:0] codes[$]);
    foreach (codes[i]) begin
      u_prog.ir_load(codes[i], exp_alt());
      ld_count = (codes[i] == tdi_select_pkg::IR_IDCODE) ? ld_count + 1 : 0;
      ovr = ovr || (ld_count >= tdi_select_pkg::IDCODE_LOADS);
      step(10);
      check("alt after load", {31'h0, alt_sel}, {31'h0, exp_alt()});
    end
  endtask
  initial begin
    repeat (100000) @(posedge i_mclk);
    fail_count++;
    test_done();
  end
  initial begin
    {i_rst_b, strap, strap_oe, programming_only_supply, func_in, func_out, hv, hv_gd} = '0;
    strap = 1'b1;
    strap_oe = 1'b1;
    seed = 32'h3424aa5d;
    step(3);
    i_rst_b = 1'b1;
    step(6);
    check("signature", sig, tdi_select_pkg::SIG_RESET);
    check("fuse", {31'h0, fuse}, 32'h0);
    check("alt at reset", {31'h0, alt_sel}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {strap_oe, strap} = i[1:0];
      step(8);
      check("alt from strap", {31'h0, alt_sel}, {31'h0, exp_alt()});
    end
    $display("test strap done");
    u_prog.reset_walk();
    seed = lfsr(seed);
    u_prog.dr_read(exp_alt(), seed, dout);
    check("id readout", dout, ID);
    step(4);
    check("tdo idle", {31'h0, tdo_oe}, 32'h0);
    $display("test idcode done");
    run_codes('{8'h16, 8'h16, 8'h16, 8'h16, 8'hff, 8'h00});
    check("override held", {31'h0, alt_sel}, 32'h1);
    u_prog.reset_walk();
    ld_count = 0;
    ovr = 1'b0;
    step(10);
    check("override cleared", {31'h0, alt_sel}, 32'h0);
    run_codes('{8'h16, 8'h16, 8'h16, 8'hff, 8'h16, 8'h16, 8'h16, 8'h16});
    $display("test override done");
    u_prog.ir_load(tdi_select_pkg::IR_SIG, exp_alt());
    seed = lfsr(seed);
    u_prog.dr_read(exp_alt(), seed, dout);
    step(10);
    check("signature old", dout, tdi_select_pkg::SIG_RESET);
    check("signature new", sig, seed);
    u_prog.ir_load(tdi_select_pkg::IR_PROGRAM, exp_alt());
    seed = lfsr(seed);
    u_prog.dr_read(exp_alt(), seed, dout);
    u_prog.ir_load(tdi_select_pkg::IR_READ_CFG, exp_alt());
    u_prog.dr_read(exp_alt(), ~seed, dout);
    check("config readback", dout, seed);
    check("config stored", cfg, seed);
    u_prog.ir_load(tdi_select_pkg::IR_FUSE, exp_alt());
    u_prog.dr_read(exp_alt(), ~seed, dout);
    u_prog.ir_load(tdi_select_pkg::IR_READ_CFG, exp_alt());
    u_prog.dr_read(exp_alt(), ~seed, dout);
    step(10);
    check("secured readback", dout, 32'h0);
    check("fuse set", {31'h0, fuse}, 32'h1);
    u_prog.ir_load(tdi_select_pkg::IR_ERASE, exp_alt());
    u_prog.reset_walk();
    ld_count = 0;
    ovr = 1'b0;
    step(10);
    check("fuse erased", {31'h0, fuse}, 32'h0);
    check("config erased", cfg, tdi_select_pkg::CFG_RESET);
    check("signature erased", sig, tdi_select_pkg::SIG_RESET);
    check("alt after erase", {31'h0, alt_sel}, 32'h0);
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      u_prog.ir_walk();
      ld_count++;
      ovr = ld_count >= tdi_select_pkg::IDCODE_LOADS;
      step(10);
      check("alt after walk", {31'h0, alt_sel}, {31'h0, exp_alt()});
    end
    $display("test walk done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      programming_only_supply = ~i[0];
      {func_in, func_out, hv, hv_gd} = seed[19:0];
      step(8);
      if (programming_only_supply) begin
        check("outputs released", {20'h0, func_oe}, 32'h0);
        check("inputs ignored", {28'h0, func_in_q}, 32'h0);
        check("gate drivers", {30'h0, hv_q & hv_gd}, 32'h0);
      end else begin
        check("outputs passed", {20'h0, func_out_q}, {20'h0, func_out});
        check("output enables", {20'h0, func_oe}, {20'h0, ~func_out});
        check("inputs passed", {28'h0, func_in_q}, {28'h0, func_in});
        check("gate outputs", {30'h0, hv_q}, {30'h0, hv});
      end
    end
    $display("test supply done");
    test_done();
  end
endmodule

// ### rtl/tdi_select.sv
// Test access port with strap and instruction driven alternate data input.
// Summary of operation
// - Strap low selects alternate data input.
// - Strap high, no override: standard input.
// - Strap high: four consecutive IDCODE loads latch alternate override.
// - Override holds until Test-Logic-Reset.
// - Test-Logic-Reset loads IDCODE instruction.
// - Programming supply alone: outputs high impedance.
// - Programming supply alone: gate drivers low.
// - Programming supply alone: ignore other inputs.
// - Configuration programmed only over test port.
// - Hold 32-bit user signature word.
// - Programmed fuse refuses configuration readout.
// - Fuse cleared only by full erase.
// - Code 0x16 selects identification register.
// - Sample rising clock, output on falling.
`timescale 1ns/1ps
module tdi_select #(
  parameter logic [31:0] ID_VALUE = 32'h12345679 // Arbitrary identification value.
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Test port pins.
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_alternate_serial_data_in,
  input wire logic i_data_input_select_strap,
  input wire logic i_data_input_select_strap_oe,
  output logic o_tdo,
  output logic o_tdo_oe,
  // Supply state.
  input wire logic i_programming_only_supply,
  // Functional pins.
  input wire logic [tdi_select_pkg::IN_WIDTH-1:0] i_func_in,
  input wire logic [tdi_select_pkg::OUT_WIDTH-1:0] i_func_out,
  input wire logic [tdi_select_pkg::HV_WIDTH-1:0] i_high_voltage_gate_output,
  input wire logic [tdi_select_pkg::HV_WIDTH-1:0] i_hv_is_gate_driver,
  output logic [tdi_select_pkg::OUT_WIDTH-1:0] o_func_out,
  output logic [tdi_select_pkg::OUT_WIDTH-1:0] o_func_out_oe,
  output logic [tdi_select_pkg::HV_WIDTH-1:0] o_high_voltage_gate_output,
  output logic [tdi_select_pkg::IN_WIDTH-1:0] o_func_in,
  // Stored configuration.
  output logic [tdi_select_pkg::SIG_WIDTH-1:0] o_user_signature_word,
  output logic [tdi_select_pkg::CFG_WIDTH-1:0] o_config,
  output logic o_readback_security_fuse,
  output logic o_alt_selected
);
  typedef struct packed {
    logic [1:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] alternate_serial_data_in_s;
    logic [1:0] strap_s;
    logic [1:0] strap_oe_s;
    logic [1:0] aps_s;
    logic tck_d;
    logic tms_d;
    logic tdi_d;
    logic alternate_serial_data_in_d;
    logic strap_d;
    logic aps_d;
    tdi_select_pkg::tap_state_t state;
    logic [7:0] ir;
    logic [7:0] ir_sh;
    logic [31:0] dr_sh;
    logic [2:0] load_count;
    logic alt_override;
    logic [31:0] sig;
    logic [31:0] cfg;
    logic fuse;
    logic tdo;
    logic tdo_oe;
    logic [tdi_select_pkg::OUT_WIDTH-1:0] fout;
    logic [tdi_select_pkg::OUT_WIDTH-1:0] fout_oe;
    logic [tdi_select_pkg::HV_WIDTH-1:0] hv;
    logic [tdi_select_pkg::IN_WIDTH-1:0] fin;
    logic alt_sel;
  } state_t;

  state_t r;
  state_t next_r;
  logic rise;
  logic fall;
  logic serial_in;
  logic strap_high;

  // Pins are first synchronised; only the second stage is ever read.
  always_comb begin
    next_r = r;
    next_r.tck_s = {r.tck_s[0], i_tck};
    next_r.tms_s = {r.tms_s[0], i_tms};
    next_r.tdi_s = {r.tdi_s[0], i_tdi};
    next_r.alternate_serial_data_in_s = {r.alternate_serial_data_in_s[0], i_alternate_serial_data_in};
    next_r.strap_s = {r.strap_s[0], i_data_input_select_strap};
    next_r.strap_oe_s = {r.strap_oe_s[0], i_data_input_select_strap_oe};
    next_r.aps_s = {r.aps_s[0], i_programming_only_supply};
    next_r.tck_d = r.tck_s[1];
    next_r.tms_d = r.tms_s[1];
    next_r.tdi_d = r.tdi_s[1];
    next_r.alternate_serial_data_in_d = r.alternate_serial_data_in_s[1];
    next_r.strap_d = r.strap_oe_s[1] ? r.strap_s[1] : 1'b1;
    next_r.aps_d = r.aps_s[1];
    rise = r.tck_s[1] & ~r.tck_d;
    fall = ~r.tck_s[1] & r.tck_d;
    strap_high = r.strap_d;
    // A low strap or a latched override both pick the alternate input.
    serial_in = (!strap_high || r.alt_override) ? r.alternate_serial_data_in_d : r.tdi_d;
    if (rise) begin
      case (r.state)
        tdi_select_pkg::TLR: next_r.state = r.tms_d ? tdi_select_pkg::TLR : tdi_select_pkg::RTI;
        tdi_select_pkg::RTI: next_r.state = r.tms_d ? tdi_select_pkg::SEL_DR : tdi_select_pkg::RTI;
        tdi_select_pkg::SEL_DR: next_r.state = r.tms_d ? tdi_select_pkg::SEL_IR : tdi_select_pkg::CAP_DR;
        tdi_select_pkg::CAP_DR: next_r.state = r.tms_d ? tdi_select_pkg::EX1_DR : tdi_select_pkg::SH_DR;
        tdi_select_pkg::SH_DR: next_r.state = r.tms_d ? tdi_select_pkg::EX1_DR : tdi_select_pkg::SH_DR;
        tdi_select_pkg::EX1_DR: next_r.state = r.tms_d ? tdi_select_pkg::UPD_DR : tdi_select_pkg::PA_DR;
        tdi_select_pkg::PA_DR: next_r.state = r.tms_d ? tdi_select_pkg::EX2_DR : tdi_select_pkg::PA_DR;
        tdi_select_pkg::EX2_DR: next_r.state = r.tms_d ? tdi_select_pkg::UPD_DR : tdi_select_pkg::SH_DR;
        tdi_select_pkg::UPD_DR: next_r.state = r.tms_d ? tdi_select_pkg::SEL_DR : tdi_select_pkg::RTI;
        tdi_select_pkg::SEL_IR: next_r.state = r.tms_d ? tdi_select_pkg::TLR : tdi_select_pkg::CAP_IR;
        tdi_select_pkg::CAP_IR: next_r.state = r.tms_d ? tdi_select_pkg::EX1_IR : tdi_select_pkg::SH_IR;
        tdi_select_pkg::SH_IR: next_r.state = r.tms_d ? tdi_select_pkg::EX1_IR : tdi_select_pkg::SH_IR;
        tdi_select_pkg::EX1_IR: next_r.state = r.tms_d ? tdi_select_pkg::UPD_IR : tdi_select_pkg::PA_IR;
        tdi_select_pkg::PA_IR: next_r.state = r.tms_d ? tdi_select_pkg::EX2_IR : tdi_select_pkg::PA_IR;
        tdi_select_pkg::EX2_IR: next_r.state = r.tms_d ? tdi_select_pkg::UPD_IR : tdi_select_pkg::SH_IR;
        default: next_r.state = r.tms_d ? tdi_select_pkg::SEL_DR : tdi_select_pkg::RTI;
      endcase
      case (r.state)
        tdi_select_pkg::TLR: begin
          next_r.ir = tdi_select_pkg::IR_IDCODE;
          next_r.load_count = tdi_select_pkg::LOAD_COUNT_RESET;
          next_r.alt_override = 1'b0;
        end
        tdi_select_pkg::CAP_IR: next_r.ir_sh = tdi_select_pkg::IR_IDCODE;
        tdi_select_pkg::SH_IR: next_r.ir_sh = {serial_in, r.ir_sh[7:1]};
        tdi_select_pkg::UPD_IR: begin
          // Capture-IR preloads IDCODE, so pure TMS walks count as loads.
          next_r.ir = r.ir_sh;
          if (r.ir_sh == tdi_select_pkg::IR_IDCODE) begin
            if (r.load_count < 3'(tdi_select_pkg::IDCODE_LOADS)) begin
              next_r.load_count = r.load_count + 3'h1;
            end
            if (strap_high && r.load_count == 3'(tdi_select_pkg::IDCODE_LOADS - 1)) begin
              next_r.alt_override = 1'b1;
            end
          end else begin
            next_r.load_count = tdi_select_pkg::LOAD_COUNT_RESET;
          end
        end
        tdi_select_pkg::CAP_DR: begin
          if (r.ir == tdi_select_pkg::IR_IDCODE) begin
            next_r.dr_sh = ID_VALUE;
          end else if (r.ir == tdi_select_pkg::IR_SIG) begin
            next_r.dr_sh = r.sig;
          end else if (r.ir == tdi_select_pkg::IR_READ_CFG) begin
            next_r.dr_sh = r.fuse ? 32'h00000000 : r.cfg;
          end else begin
            next_r.dr_sh = 32'h00000000;
          end
        end
        tdi_select_pkg::SH_DR: begin
          if (r.ir == tdi_select_pkg::IR_BYPASS) begin
            next_r.dr_sh = {31'h00000000, serial_in};
          end else begin
            next_r.dr_sh = {serial_in, r.dr_sh[31:1]};
          end
        end
        tdi_select_pkg::UPD_DR: begin
          // Configuration changes only through the test port.
          if (r.ir == tdi_select_pkg::IR_PROGRAM) begin
            next_r.cfg = r.dr_sh;
          end else if (r.ir == tdi_select_pkg::IR_SIG) begin
            next_r.sig = r.dr_sh;
          end else if (r.ir == tdi_select_pkg::IR_FUSE) begin
            next_r.fuse = 1'b1;
          end
        end
        tdi_select_pkg::RTI: begin
          if (r.ir == tdi_select_pkg::IR_ERASE) begin
            next_r.cfg = tdi_select_pkg::CFG_RESET;
            next_r.sig = tdi_select_pkg::SIG_RESET;
            next_r.fuse = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (fall) begin
      next_r.tdo_oe = (r.state == tdi_select_pkg::SH_DR) || (r.state == tdi_select_pkg::SH_IR);
      next_r.tdo = (r.state == tdi_select_pkg::SH_IR) ? r.ir_sh[0] : r.dr_sh[0];
    end
    // Without the core supplies the pins fall back to a safe state.
    next_r.fout = r.aps_d ? '0 : i_func_out;
    // Open-drain pins are driven only while they pull low.
    next_r.fout_oe = r.aps_d ? '0 : ~i_func_out;
    next_r.hv = r.aps_d ? (i_high_voltage_gate_output & ~i_hv_is_gate_driver) :
                i_high_voltage_gate_output;
    next_r.fin = r.aps_d ? '0 : i_func_in;
    // Registered so that the select flag tracks its sources without a glitch.
    next_r.alt_sel = !next_r.strap_d || next_r.alt_override;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
      r.state <= tdi_select_pkg::TLR;
      r.ir <= tdi_select_pkg::IR_IDCODE;
      r.sig <= tdi_select_pkg::SIG_RESET;
      r.strap_d <= 1'b1;
      r.aps_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_tdo = r.tdo;
  assign o_tdo_oe = r.tdo_oe;
  assign o_func_out = r.fout;
  assign o_func_out_oe = r.fout_oe;
  assign o_high_voltage_gate_output = r.hv;
  assign o_func_in = r.fin;
  assign o_user_signature_word = r.sig;
  assign o_config = r.cfg;
  assign o_readback_security_fuse = r.fuse;
  assign o_alt_selected = r.alt_sel;

  sequence s_tlr;
    r.state == tdi_select_pkg::TLR;
  endsequence

  a_strap_low_alt: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !r.strap_d |-> o_alt_selected) else $error("Low strap did not pick alternate input.");
  a_strap_high_std: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (r.strap_d && !r.alt_override) |-> !o_alt_selected) else $error("Standard input not picked.");
  a_override_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (rise && r.state == tdi_select_pkg::UPD_IR && r.ir_sh == tdi_select_pkg::IR_IDCODE
     && r.strap_d && r.load_count == 3'h3) |=> r.alt_override)
    else $error("Fourth IDCODE load did not set override.");
  a_override_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s_tlr ##0 rise) |=> !r.alt_override) else $error("Override survived reset state.");
  a_tlr_idcode: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s_tlr ##0 rise) |=> r.ir == tdi_select_pkg::IR_IDCODE) else $error("IDCODE not loaded.");
  a_aps_outputs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $past(r.aps_d) && r.aps_d |-> o_func_out_oe == '0) else $error("Output driven on PROGRAMMING_ONLY_SUPPLY.");
  a_aps_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    r.aps_d |=> (o_high_voltage_gate_output & $past(i_hv_is_gate_driver)) == '0)
    else $error("Gate driver not low on PROGRAMMING_ONLY_SUPPLY.");
  a_aps_inputs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    r.aps_d |=> o_func_in == '0) else $error("Input passed on PROGRAMMING_ONLY_SUPPLY.");
  a_fuse_block: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (rise && r.fuse && r.state == tdi_select_pkg::CAP_DR && r.ir == tdi_select_pkg::IR_READ_CFG)
    |=> r.dr_sh == 32'h00000000) else $error("Secured configuration read out.");
  a_fuse_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ($past(r.fuse) && !r.fuse) |-> $past(r.ir) == tdi_select_pkg::IR_ERASE)
    else $error("Fuse cleared without erase.");
  a_count_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (rise && r.state == tdi_select_pkg::UPD_IR && r.ir_sh != tdi_select_pkg::IR_IDCODE)
    |=> r.load_count == 3'h0) else $error("Count did not restart.");
endmodule

// ### rtl/tdi_select_pkg.sv
// Constants shared by the alternate data input select block.
package tdi_select_pkg;
  localparam int IR_WIDTH = 8;
  localparam logic [7:0] IR_IDCODE = 8'h16;
  localparam logic [7:0] IR_BYPASS = 8'hff;
  localparam logic [7:0] IR_CAPTURE_PATTERN = 8'h01;
  localparam int ID_WIDTH = 32;
  localparam int SIG_WIDTH = 32;
  localparam int CFG_WIDTH = 32;
  localparam int IDCODE_LOADS = 4;
  localparam logic [2:0] LOAD_COUNT_RESET = 3'h0;
  localparam logic [31:0] SIG_RESET = 32'hffffffff;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [7:0] IR_PROGRAM = 8'h30;
  localparam logic [7:0] IR_ERASE = 8'h03;
  localparam logic [7:0] IR_READ_CFG = 8'h31;
  localparam logic [7:0] IR_SIG = 8'h32;
  localparam logic [7:0] IR_FUSE = 8'h33;
  localparam int HV_WIDTH = 2;
  localparam int OUT_WIDTH = 12;
  localparam int IN_WIDTH = 4;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } tap_state_t;
endpackage
